/* capture_bridge_regs.vh */
`ifndef CAPTURE_BRIDGE_REGS_VH
`define CAPTURE_BRIDGE_REGS_VH
// Output word width toward the FIFO and the cable
`define WORD_W 16
// Bits per sample for the two sample widths
`define SAMPLE_W16 6'h10
`define SAMPLE_W24 6'h18
// Power-up configuration load length in memory clock cycles, two clock cycles each
`define CFG_LOAD_CYCLES 16'h0400
// Cable strobe: cycles high and cycles low per transfer
`define XFER_STROBE_HI 4'h2
`define XFER_STROBE_LO 4'h2
// Transfer state codes
`define XS_IDLE 2'h0
`define XS_READ 2'h1
`define XS_HIGH 2'h2
`define XS_LOW 2'h3
`endif

/* capture_bridge.v */
// Behaviour
// - Accept 16 or 24-bit framed I/Q samples
// - Pack serial frame bits into 16-bit words
// - Pace FIFO-to-card transfers with handshake strobe
// - Undecimated mode bypasses FIFO, one sample per converter clock
// - Steer control data line by write or read
// - Load configuration from serial memory at power-up
// - Light done LED after configuration loaded
`timescale 1ns/1ps
`include "capture_bridge_regs.vh"
module capture_bridge #(
   parameter CFG_CYCLES = `CFG_LOAD_CYCLES
) (
   // Clock, enable, reset
   input wire clk,
   input wire clkEn,
   input wire sys_rst,
   // Mode selects from the host
   input wire wide24,
   input wire undecimated,
   // Framed serial output port of the receiver
   input wire serClk,
   input wire serFrame,
   input wire serData,
   input wire [1:0] rawSample,
   // Serial configuration memory
   output reg cfgMemClk,
   input wire cfgMemData,
   output reg cfgDone,
   // FIFO write side
   output reg [15:0] fifoWrData,
   output reg fifoWrEn_n,
   // FIFO read side
   input wire [15:0] fifoRdData,
   input wire fifoEmpty_n,
   output reg fifoRdEn_n,
   // Capture card cable
   output reg [15:0] cardData,
   output reg cardReq,
   input wire cardAck,
   // Control port toward host and receiver
   input wire hostSelect,
   input wire hostClock,
   input wire hostDataIn,
   input wire hostReadDir,
   output reg ctrl_port_select,
   output reg ctrl_port_clock,
   output reg ctrlPortDataOut,
   output reg ctrlPortDataOe,
   input wire ctrlPortDataIn,
   output reg hostDataOut
);

   // Two-flop synchronisers for every outside input except the FIFO read side, clkEn and sys_rst
   reg [1:0] s1_r;
   reg [1:0] s2_r;
   reg [3:0] sA1_r;
   reg [3:0] sA2_r;
   reg [7:0] sB1_r;
   reg [7:0] sB2_r;
   reg serClkD_r;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r <= 2'h0;
         s2_r <= 2'h0;
         sA1_r <= 4'h0;
         sA2_r <= 4'h0;
         sB1_r <= 8'h0;
         sB2_r <= 8'h0;
         serClkD_r <= 1'b0;
      end else if (clkEn) begin
         s1_r <= {serFrame, serData};
         s2_r <= s1_r;
         sA1_r <= {serClk, rawSample, cardAck};
         sA2_r <= sA1_r;
         sB1_r <= {wide24, undecimated, hostSelect, hostClock, hostDataIn, hostReadDir,
            ctrlPortDataIn, cfgMemData};
         sB2_r <= sB1_r;
         serClkD_r <= sA2_r[3];
      end
   end

   wire serRise = sA2_r[3] & ~serClkD_r;
   wire frameS = s2_r[1];
   wire dataS = s2_r[0];
   wire ackS = sA2_r[0];
   wire modeW24 = sB2_r[7];
   wire modeRaw = sB2_r[6];

   // Power-up configuration load from serial memory
   reg [15:0] cfgCnt_r;
   reg [15:0] cfgShift_r;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfgCnt_r <= 16'h0000;
         cfgShift_r <= 16'h0000;
         cfgMemClk <= 1'b0;
         cfgDone <= 1'b0;
      end else if (clkEn && !cfgDone) begin
         cfgMemClk <= ~cfgMemClk;
         if (cfgMemClk) begin
            cfgShift_r <= {cfgShift_r[14:0], sB2_r[0]};
            cfgCnt_r <= cfgCnt_r + 16'h0001;
            if (cfgCnt_r == CFG_CYCLES[15:0] - 16'h0001) begin
               cfgDone <= 1'b1;
               cfgMemClk <= 1'b0;
            end
         end
      end
   end

   // Frame packer: bits into 16-bit words
   reg [5:0] bitCnt_r; // Up to 48 bits per frame
   reg [4:0] wordBit_r;
   reg [15:0] pack_r;
   reg inFrame_r;
   wire [5:0] sampleLen = modeW24 ? `SAMPLE_W24 : `SAMPLE_W16;
   wire [15:0] packNxt = {pack_r[14:0], dataS};
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bitCnt_r <= 6'h00;
         wordBit_r <= 5'h00;
         pack_r <= 16'h0000;
         inFrame_r <= 1'b0;
         fifoWrData <= 16'h0000;
         fifoWrEn_n <= 1'b1;
      end else if (clkEn) begin
         fifoWrEn_n <= 1'b1;
         if (cfgDone && !modeRaw && serRise) begin
            if (frameS) begin
               // Frame sync: fresh word boundary
               inFrame_r <= 1'b1;
               bitCnt_r <= 6'h01;
               wordBit_r <= 5'h01;
               pack_r <= {15'h0000, dataS};
            end else if (inFrame_r) begin
               pack_r <= packNxt;
               wordBit_r <= (wordBit_r == 5'h0f) ? 5'h00 : wordBit_r + 5'h01;
               if (wordBit_r == 5'h0f) begin
                  fifoWrData <= packNxt;
                  fifoWrEn_n <= 1'b0;
               end
               // Two samples (I then Q) per frame; stop after both
               if (bitCnt_r == sampleLen + sampleLen - 6'h01) begin
                  inFrame_r <= 1'b0;
                  if (wordBit_r != 5'h0f) begin
                     // Flush a partial word, left aligned
                     fifoWrData <= packNxt << (5'h0f - wordBit_r);
                     fifoWrEn_n <= 1'b0;
                  end
               end
               bitCnt_r <= bitCnt_r + 6'h01;
            end
         end
      end
   end

   // FIFO-to-card pacing and raw bypass
   reg [1:0] xs_r;
   reg [3:0] tCnt_r;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xs_r <= `XS_IDLE;
         tCnt_r <= 4'h0;
         fifoRdEn_n <= 1'b1;
         cardData <= 16'h0000;
         cardReq <= 1'b0;
      end else if (clkEn) begin
         fifoRdEn_n <= 1'b1;
         if (modeRaw) begin
            // Buffered raw modulator output per converter clock
            xs_r <= `XS_IDLE;
            cardReq <= serRise & cfgDone;
            if (serRise && cfgDone) begin
               cardData <= {14'h0000, sA2_r[2:1]};
            end
         end else begin
            case (xs_r)
               `XS_IDLE: begin
                  cardReq <= 1'b0;
                  if (cfgDone && fifoEmpty_n && !ackS) begin
                     fifoRdEn_n <= 1'b0;
                     xs_r <= `XS_READ;
                  end
               end
               `XS_READ: begin
                  // FIFO registers the word on this edge
                  tCnt_r <= 4'h0;
                  xs_r <= `XS_HIGH;
               end
               `XS_HIGH: begin
                  // Read data stands one cycle after the read strobe
                  if (tCnt_r == 4'h0) begin
                     cardData <= fifoRdData;
                  end
                  cardReq <= 1'b1;
                  // Saturate so a slow card never relatches the word
                  if (tCnt_r != 4'hf) begin
                     tCnt_r <= tCnt_r + 4'h1;
                  end
                  if (tCnt_r >= `XFER_STROBE_HI - 4'h1 && ackS) begin
                     tCnt_r <= 4'h0;
                     xs_r <= `XS_LOW;
                  end
               end
               `XS_LOW: begin
                  cardReq <= 1'b0;
                  tCnt_r <= tCnt_r + 4'h1;
                  if (tCnt_r >= `XFER_STROBE_LO - 4'h1 && !ackS) begin
                     xs_r <= `XS_IDLE;
                  end
               end
               default: xs_r <= `XS_IDLE;
            endcase
         end
      end
   end

   // Control port buffering and data line direction
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_port_select <= 1'b1;
         ctrl_port_clock <= 1'b0;
         ctrlPortDataOut <= 1'b0;
         ctrlPortDataOe <= 1'b0;
         hostDataOut <= 1'b0;
      end else if (clkEn) begin
         ctrl_port_select <= sB2_r[5];
         ctrl_port_clock <= sB2_r[4];
         ctrlPortDataOut <= sB2_r[3];
         ctrlPortDataOe <= cfgDone & ~sB2_r[2];
         hostDataOut <= sB2_r[2] ? sB2_r[1] : 1'b0;
      end
   end

endmodule // capture_bridge

/* capture_bridge_sva.sv */
`timescale 1ns/1ps
module capture_bridge_sva (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Watched ports
   input wire undecimated,
   input wire hostClock,
   input wire cfgDone,
   input wire fifoWrEn_n,
   input wire [15:0] cardData,
   input wire cardReq,
   input wire ctrl_port_clock,
   input wire ctrlPortDataOe,
   input wire hostDataOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // No FIFO write or cable request before load
   cfg_gate_a: assert property (!cfgDone |-> fifoWrEn_n && !cardReq) else $error("early");
   done_held_a: assert property (cfgDone |=> cfgDone) else $error("done");
   wr_pulse_a: assert property (!fifoWrEn_n |=> fifoWrEn_n) else $error("wr");
   // Cable strobe pacing
   req_hold_a: assert property ($rose(cardReq) && !undecimated && !$past(undecimated, 4)
      |=> cardReq && $stable(cardData)) else $error("hold");
   req_low_a: assert property ($fell(cardReq) && !undecimated |=> !cardReq) else $error("low");
   // Raw mode
   raw_nofifo_a: assert property ($past(undecimated, 4) && undecimated |-> fifoWrEn_n)
      else $error("raw");
   raw_pulse_a: assert property (cardReq && $past(undecimated, 4) && undecimated
      |=> !cardReq) else $error("pulse");
   // Control port copies
   ctl_copy_a: assert property (ctrl_port_clock == $past(hostClock, 3)) else $error("ck");
   dir_a: assert property (ctrlPortDataOe |-> !hostDataOut) else $error("dir");
endmodule // capture_bridge_sva
bind capture_bridge capture_bridge_sva i_sva (
   .clk(clk), .sys_rst(sys_rst), .undecimated(undecimated), .hostClock(hostClock),
   .cfgDone(cfgDone), .fifoWrEn_n(fifoWrEn_n), .cardData(cardData), .cardReq(cardReq),
   .ctrl_port_clock(ctrl_port_clock), .ctrlPortDataOe(ctrlPortDataOe),
   .hostDataOut(hostDataOut)
);

/* card_model.sv */
`timescale 1ns/1ps
module card_model (
   // Clock and pacing
   input wire clk,
   input wire [31:0] ackDly,
   // FIFO
   input wire [15:0] fifoWrData,
   input wire fifoWrEn_n,
   input wire fifoRdEn_n,
   output logic [15:0] fifoRdData,
   output logic fifoEmpty_n,
   // Cable
   input wire [15:0] cardData,
   input wire cardReq,
   output logic cardAck
);
   logic [15:0] fifo[$];
   logic [15:0] got[$];
   int cnt = 0;
   initial begin
      fifoRdData = 16'h0000;
      fifoEmpty_n = 0;
      cardAck = 0;
   end
   // FIFO store, idle read bus toggles; card acks after ackDly cycles
   always @(posedge clk) begin
      if (!fifoWrEn_n) fifo.push_back(fifoWrData);
      fifoRdData <= (!fifoRdEn_n && fifo.size() > 0) ? fifo.pop_front() : ~fifoRdData;
      fifoEmpty_n <= fifo.size() != 0;
      if (!cardReq) begin
         cardAck <= 0;
         cnt = 0;
      end else if (!cardAck && ++cnt > ackDly) begin
         cardAck <= 1;
         got.push_back(cardData);
      end
   end
endmodule // card_model

/* capture_bridge_bench.sv */
`timescale 1ns/1ps
module capture_bridge_bench;
   logic clk = 0, clkEn = 1, sys_rst = 1, wide24 = 0, undecimated = 0, serClk = 0, serFrame = 0;
   logic serData = 0, cfgMemData = 0, hostSelect = 1, hostClock = 0, hostDataIn = 0;
   logic hostReadDir = 0, rxBit = 0;
   logic [1:0] rawSample = 2'h0;
   wire cfgMemClk, cfgDone, fifoWrEn_n, fifoRdEn_n, cardReq, cardAck, fifoEmpty_n, hostDataOut;
   wire ctrl_port_select, ctrl_port_clock, ctrlPortDataOut, ctrlPortDataOe, ctrlPortDataIn;
   wire [15:0] fifoWrData, fifoRdData, cardData;
   int ackDly = 1, fails = 0, tests_run = 0, cyc = 0, k;
   capture_bridge #(.CFG_CYCLES(8)) i_dut (
      .clk(clk), .clkEn(clkEn), .sys_rst(sys_rst), .wide24(wide24), .undecimated(undecimated),
      .serClk(serClk), .serFrame(serFrame), .serData(serData), .rawSample(rawSample),
      .cfgMemClk(cfgMemClk), .cfgMemData(cfgMemData), .cfgDone(cfgDone),
      .fifoWrData(fifoWrData), .fifoWrEn_n(fifoWrEn_n), .fifoRdData(fifoRdData),
      .fifoEmpty_n(fifoEmpty_n), .fifoRdEn_n(fifoRdEn_n), .cardData(cardData),
      .cardReq(cardReq), .cardAck(cardAck), .hostSelect(hostSelect), .hostClock(hostClock),
      .hostDataIn(hostDataIn), .hostReadDir(hostReadDir),
      .ctrl_port_select(ctrl_port_select), .ctrl_port_clock(ctrl_port_clock),
      .ctrlPortDataOut(ctrlPortDataOut), .ctrlPortDataOe(ctrlPortDataOe),
      .ctrlPortDataIn(ctrlPortDataIn), .hostDataOut(hostDataOut)
   );
   card_model i_card (
      .clk(clk), .ackDly(ackDly), .fifoWrData(fifoWrData), .fifoWrEn_n(fifoWrEn_n),
      .fifoRdEn_n(fifoRdEn_n), .fifoRdData(fifoRdData), .fifoEmpty_n(fifoEmpty_n),
      .cardData(cardData), .cardReq(cardReq), .cardAck(cardAck)
   );
   // Shared control data line
   assign ctrlPortDataIn = ctrlPortDataOe ? ctrlPortDataOut : rxBit;
   initial forever #50 clk = ~clk;
   always @(posedge clk) if (++cyc == 20000) begin fails++; summarize; end
   task summarize;
      if (fails == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end
   endtask
   task sendBits(input logic [47:0] b, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serFrame = (i == n - 1); serData = b[i]; serClk = 0;
         repeat (4) @(negedge clk);
         serClk = 1;
         repeat (4) @(negedge clk);
      end
      serClk = 0; serFrame = 0; serData = ~serData;
      repeat (4) @(negedge clk);
   endtask
   task expWords(input logic [15:0] w[$]);
      k = 0;
      while (i_card.got.size() < w.size() && k < 3000) begin @(negedge clk); k++; end
      foreach (w[j]) chk("word", w[j], i_card.got.size() > j ? i_card.got[j] : 16'hxxxx);
      i_card.got.delete();
   endtask
   task tCfg;
      chk("cfgDone", 0, cfgDone);
      @(negedge clk);
      chk("cfgMemClk", 1, cfgMemClk);
      repeat (20) @(negedge clk);
      chk("cfgDone", 1, cfgDone);
      chk("cfgMemClk", 0, cfgMemClk);
   endtask
   task tFrames;
      sendBits(48'h0000a5c31e7f, 32);
      sendBits(48'h00000000f0f5, 20);
      ackDly = 6;
      sendBits(48'h000012345678, 32);
      expWords('{16'ha5c3, 16'h1e7f, 16'h0f0f, 16'h1234, 16'h5678});
      ackDly = 1;
   endtask
   task tWide;
      wide24 = 1;
      repeat (8) @(negedge clk);
      sendBits(48'h123456abcdef, 48);
      expWords('{16'h1234, 16'h56ab, 16'hcdef});
      wide24 = 0;
   endtask
   task tRaw;
      undecimated = 1;
      repeat (8) @(negedge clk);
      for (int v = 0; v < 4; v++) begin
         rawSample = v[1:0]; serClk = 1;
         k = 0;
         while (cardReq !== 1'b1 && k < 8) begin @(negedge clk); k++; end
         chk("rawReq", 1, cardReq);
         chk("raw", {14'h0000, rawSample}, cardData);
         serClk = 0;
         repeat (6) @(negedge clk);
      end
      chk("fifo", 0, i_card.fifo.size());
      undecimated = 0;
      repeat (8) @(negedge clk);
   endtask
   task tCtrl;
      hostDataIn = 1;
      hostClock = 1;
      hostSelect = 0;
      repeat (5) @(negedge clk);
      chk("oe", 1, ctrlPortDataOe);
      chk("out", 1, ctrlPortDataOut);
      chk("sel", 0, ctrl_port_select);
      chk("pclk", 1, ctrl_port_clock);
      hostReadDir = 1;
      hostDataIn = 0;
      rxBit = 0;
      repeat (8) @(negedge clk);
      chk("oe", 0, ctrlPortDataOe);
      chk("rd", 0, hostDataOut);
      rxBit = 1;
      repeat (8) @(negedge clk);
      chk("rd", 1, hostDataOut);
   endtask
   // Converter taken as tuned before capture starts
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 0;
      tCfg;
      tFrames;
      tWide;
      tRaw;
      tCtrl;
      summarize;
   end
endmodule // capture_bridge_bench
